// ### inc/repair_hdr_defines.svh
/*
  Offsets, field positions, reset values and fixed codes of the repair
  header builder. Assumes inclusion by bare name from design and bench files.
*/
`ifndef REPAIR_HDR_DEFINES_SVH
`define REPAIR_HDR_DEFINES_SVH

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_BLOCK 12'h004
`define REG_PTYPE 12'h008
`define REG_SEED 12'h00c
`define REG_STATUS 12'h010
`define REG_SEQ 12'h014
`define REG_SSRC 12'h018
`define REG_TIME 12'h01c

// Control bits
`define CTRL_ENABLE 0
`define CTRL_RESEED 1
`define CTRL_COLLIDE 2

// Header constants
`define RTP_VERSION 2'h2
`define CODE_KIND_XOR 3'h0
`define FEC_HDR_OCTETS 5'h10
`define RTP_HDR_OCTETS 5'h0c
`define FRAME_OCTETS 6'h1c
`define LFSR_TAPS 32'h80200003
`define LFSR_RESET 32'h1d872b41
`define COUNT_ZERO 8'h00

// Response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### inc/repair_hdr_pkg.sv
/*
  Types of the repair header builder: the per-packet protected-field summary
  and the byte stream beat. Assumes the defines header is available.
*/
`default_nettype none
package repair_hdr_pkg;

  // Fields of one source packet that the repair packet protects
  typedef struct packed {
    logic padding;
    logic extension;
    logic [3:0] csrc_count;
    logic marker;
    logic [6:0] ptype;
    logic [15:0] seq;
    logic [31:0] stamp;
    logic [15:0] length;
  } src_fields_t;

  // One byte of the outgoing header stream
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } beat_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COLLECT = 2'b01,
    ST_EMIT = 2'b10
  } build_state_t;

endpackage
`default_nettype wire

// ### src/repair_hdr_builder.sv
/*
  Repair packet header builder: folds the protected header fields of the
  source packets of one column by XOR and streams a 12-octet RTP header and
  a 16-octet FEC header, one byte a cycle. Registers over AXI4-Lite.
  Assumes a source-side parser presents one src_fields_t per source packet
  and that the parity payload engine appends the payload after last.
*/
`default_nettype none
`include "repair_hdr_defines.svh"

module repair_hdr_builder
  import repair_hdr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [ADDR_W-1:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // Source packet field summaries
  input wire src_fields_t src_fields_i,
  input wire logic src_valid_i,
  output logic src_ready_o,
  // Repair header byte stream
  output beat_t hdr_beat_o,
  output logic hdr_valid_o,
  input wire logic hdr_ready_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    lfsr_step = {v[30:0], 1'b0} ^ (v[31] ? `LFSR_TAPS : 32'h00000000);
  endfunction

  // Wrap-aware "a precedes b" for 16-bit sequence numbers
  function automatic logic seq_before(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] d;
    d = b - a;
    seq_before = (d != 16'h0000) && !d[15];
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      apply_strb[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] ctrl_r;
  logic [31:0] block_r;
  logic [31:0] ptype_r;
  logic [31:0] seed_r;
  logic [31:0] time_r;
  logic [31:0] lfsr_r;
  logic [15:0] seq_r;
  logic [31:0] ssrc_r;
  logic cfg_err_r;
  logic [15:0] sent_r;

  logic [ADDR_W-1:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;

  wire logic [7:0] col_count = block_r[7:0];
  wire logic [7:0] row_count = block_r[15:8];
  wire logic cfg_ok = (col_count != `COUNT_ZERO) && (row_count != `COUNT_ZERO);
  wire logic enabled = ctrl_r[`CTRL_ENABLE];

  wire logic aw_take = s_awvalid_i && s_awready_o;
  wire logic w_take = s_wvalid_i && s_wready_o;
  wire logic wr_fire = aw_held_r && w_held_r && !s_bvalid_o;
  wire logic wr_ctrl = wr_fire && (awaddr_r == `REG_CTRL);
  wire logic wr_block = wr_fire && (awaddr_r == `REG_BLOCK);
  wire logic wr_ptype = wr_fire && (awaddr_r == `REG_PTYPE);
  wire logic wr_seed = wr_fire && (awaddr_r == `REG_SEED);
  wire logic wr_map = wr_ctrl || wr_block || wr_ptype || wr_seed
                      || (awaddr_r == `REG_STATUS) || (awaddr_r == `REG_SEQ)
                      || (awaddr_r == `REG_SSRC) || (awaddr_r == `REG_TIME);
  wire logic [31:0] wr_val_ctrl = apply_strb(ctrl_r, wdata_r, wstrb_r);
  wire logic reseed_req = wr_ctrl && wr_val_ctrl[`CTRL_RESEED];
  wire logic collide_req = wr_ctrl && wr_val_ctrl[`CTRL_COLLIDE];
  wire logic [31:0] wr_val_block = apply_strb(block_r, wdata_r, wstrb_r);
  wire logic [31:0] wr_val_ptype = apply_strb(ptype_r, wdata_r, wstrb_r);

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_bvalid_o <= 1'b0;
      s_bresp_o <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_awaddr_i;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= s_wdata_i;
        wstrb_r <= s_wstrb_i;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  always_comb begin
    s_awready_o = !aw_held_r && !s_bvalid_o;
    s_wready_o = !w_held_r && !s_bvalid_o;
  end

  // Self-clearing command bits are not stored; only enable persists
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= 32'h00000000;
      block_r <= 32'h00000000;
      ptype_r <= 32'h00000000;
      seed_r <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= {31'h00000000, wr_val_ctrl[`CTRL_ENABLE]};
      end
      if (wr_block) begin
        block_r <= {16'h0000, wr_val_block[15:0]};
      end
      if (wr_ptype) begin
        ptype_r <= {25'h0000000, wr_val_ptype[6:0]};
      end
      if (wr_seed) begin
        seed_r <= apply_strb(seed_r, wdata_r, wstrb_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_araddr_i)
      `REG_CTRL: rd_mux = ctrl_r;
      `REG_BLOCK: rd_mux = block_r;
      `REG_PTYPE: rd_mux = ptype_r;
      `REG_SEED: rd_mux = seed_r;
      `REG_STATUS: rd_mux = {sent_r, 15'h0000, cfg_err_r};
      `REG_SEQ: rd_mux = {16'h0000, seq_r};
      `REG_SSRC: rd_mux = ssrc_r;
      `REG_TIME: rd_mux = time_r;
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_rvalid_o <= 1'b0;
      s_rdata_o <= 32'h00000000;
      s_rresp_o <= `RESP_OKAY;
    end else if (s_arvalid_i && s_arready_o) begin
      s_rvalid_o <= 1'b1;
      s_rdata_o <= rd_mux;
      s_rresp_o <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_rvalid_o && s_rready_i) begin
      s_rvalid_o <= 1'b0;
    end
  end

  always_comb begin
    s_arready_o = !s_rvalid_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Free-running entropy and transmission clock

  // The LFSR runs every cycle, so its state at software's reseed request
  // depends on boot timing and the seed; that is the source of randomness.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lfsr_r <= `LFSR_RESET;
      time_r <= 32'h00000000;
    end else begin
      lfsr_r <= wr_seed ? (lfsr_step(lfsr_r) ^ wdata_r) : lfsr_step(lfsr_r);
      time_r <= time_r + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Column accumulation and header emission

  build_state_t state_r, state_nxt;
  src_fields_t acc_r;
  logic [15:0] base_r;
  logic [31:0] tx_time_r;
  logic [7:0] rows_seen_r;
  logic [4:0] byte_idx_r;
  logic [7:0] hdr_bytes [0:27];

  wire logic src_take = src_valid_i && src_ready_o;
  wire logic last_row = (rows_seen_r + 8'h01) == row_count;
  wire logic beat_take = hdr_valid_o && hdr_ready_i;
  // The parity payload engine starts right after this byte
  wire logic last_byte = byte_idx_r == 5'(`FRAME_OCTETS - 6'h01);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (enabled && cfg_ok) state_nxt = ST_COLLECT;
      ST_COLLECT: begin
        if (!(enabled && cfg_ok)) begin
          state_nxt = ST_IDLE;
        end else if (src_take && last_row) begin
          state_nxt = ST_EMIT;
        end
      end
      ST_EMIT: if (beat_take && last_byte) state_nxt = enabled && cfg_ok ? ST_COLLECT : ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cfg_err_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_err_r <= enabled && !cfg_ok;
    end
  end

  always_comb begin
    // Gated by config too, so a bad count refuses sources at once
    src_ready_o = (state_r == ST_COLLECT) && enabled && cfg_ok;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r <= '0;
      base_r <= 16'h0000;
      rows_seen_r <= 8'h00;
      tx_time_r <= 32'h00000000;
    end else if (src_take) begin
      rows_seen_r <= last_row ? 8'h00 : rows_seen_r + 8'h01;
      // Latched once so the four timestamp bytes cannot tear while streaming
      if (last_row) begin
        tx_time_r <= time_r;
      end
      if (rows_seen_r == 8'h00) begin
        acc_r <= src_fields_i;
        base_r <= src_fields_i.seq;
      end else begin
        acc_r <= acc_r ^ src_fields_i;
        if (seq_before(src_fields_i.seq, base_r)) begin
          base_r <= src_fields_i.seq;
        end
      end
    end else if (state_r == ST_IDLE) begin
      // A column cut short by a config change restarts from row zero
      rows_seen_r <= 8'h00;
    end
  end

  // Repair sequence and identifier
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_r <= 16'h0000;
      ssrc_r <= 32'h00000000;
      sent_r <= 16'h0000;
    end else begin
      if (reseed_req) begin
        seq_r <= lfsr_r[15:0];
        ssrc_r <= lfsr_r ^ seed_r;
      end else begin
        if (collide_req) begin
          ssrc_r <= lfsr_step(lfsr_r) ^ ssrc_r;
        end
        if (beat_take && last_byte) begin
          seq_r <= seq_r + 16'h0001;
          sent_r <= sent_r + 16'h0001;
        end
      end
    end
  end

  // Header image, big-endian: 12-octet RTP header then 16-octet FEC header.
  // No padding, extension or CSRC octets follow, whatever the flags say.
  wire logic [95:0] rtp_hdr = {`RTP_VERSION, acc_r.padding, acc_r.extension,
                               acc_r.csrc_count, acc_r.marker, ptype_r[6:0],
                               seq_r, tx_time_r, ssrc_r};
  wire logic [127:0] fec_hdr = {base_r, acc_r.length, 1'b1, acc_r.ptype,
                                24'h000000, acc_r.stamp, 1'b0, 1'b0,
                                `CODE_KIND_XOR, 3'h0, col_count, row_count,
                                8'h00};
  wire logic [223:0] hdr_image = {rtp_hdr, fec_hdr};

  always_comb begin
    for (int i = 0; i < 28; i++) begin
      hdr_bytes[i] = hdr_image[223 - i*8 -: 8];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      byte_idx_r <= 5'h00;
      hdr_valid_o <= 1'b0;
      hdr_beat_o <= '0;
    end else if (state_r == ST_EMIT) begin
      if (!hdr_valid_o) begin
        hdr_valid_o <= 1'b1;
        hdr_beat_o <= '{data: hdr_bytes[byte_idx_r], last: last_byte};
      end else if (hdr_ready_i) begin
        if (last_byte) begin
          hdr_valid_o <= 1'b0;
          byte_idx_r <= 5'h00;
        end else begin
          byte_idx_r <= byte_idx_r + 5'h01;
          hdr_beat_o <= '{data: hdr_bytes[byte_idx_r + 5'h01],
                          last: (byte_idx_r + 5'h01) == 5'(`FRAME_OCTETS - 6'h01)};
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### verification/repair_hdr_builder_sva.sv
/*
  Checker of the repair header byte stream.
  Assumes binding to repair_hdr_builder and a single clock domain.
*/
`default_nettype none
module repair_hdr_builder_sva
  import repair_hdr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Source side
  input wire logic src_valid_i,
  input wire logic src_ready_o,
  // Header stream
  input wire beat_t hdr_beat_o,
  input wire logic hdr_valid_o,
  input wire logic hdr_ready_i
);
  logic [4:0] pos_r;
  wire logic take_w = hdr_valid_o && hdr_ready_i;
  wire logic src_take_w = src_valid_i && src_ready_o;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      pos_r <= 5'h00;
    else if (take_w)
      pos_r <= hdr_beat_o.last ? 5'h00 : pos_r + 5'h01;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  AST_BEAT_HOLD: assert property (hdr_valid_o && !hdr_ready_i |=>
    hdr_valid_o && $stable(hdr_beat_o)) else $error("beat changed while stalled");
  AST_LAST_POS: assert property (hdr_valid_o |->
    hdr_beat_o.last == (pos_r == 5'h1b)) else $error("last flag off byte 27");
  AST_VERSION: assert property (hdr_valid_o && pos_r == 5'h00 |->
    hdr_beat_o.data[7:6] == 2'h2) else $error("version not 2");
  AST_EXT_FLAG: assert property (hdr_valid_o && pos_r == 5'h10 |->
    hdr_beat_o.data[7]) else $error("extension flag clear");
  AST_UNUSED: assert property (hdr_valid_o &&
    (pos_r inside {5'h11, 5'h12, 5'h13, 5'h18, 5'h1b}) |-> hdr_beat_o.data == 8'h00)
    else $error("unused field not zero");
  AST_END: assert property (take_w && hdr_beat_o.last |=> !hdr_valid_o)
    else $error("bytes after last");
  AST_START: assert property ($rose(hdr_valid_o) |->
    pos_r == 5'h00 && $past(src_take_w, 2)) else $error("header not after block");
  AST_NO_SRC: assert property (hdr_valid_o |-> !src_ready_o)
    else $error("source taken while emitting");
endmodule

bind repair_hdr_builder repair_hdr_builder_sva u_repair_hdr_builder_sva (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .src_valid_i(src_valid_i),
  .src_ready_o(src_ready_o), .hdr_beat_o(hdr_beat_o), .hdr_valid_o(hdr_valid_o),
  .hdr_ready_i(hdr_ready_i));
`default_nettype wire

// ### verification/hdr_sink_model.sv
/*
  Receiver model: takes header bytes, stalling one cycle in four.
  Assumes the same clock and reset as the builder.
*/
`default_nettype none
module hdr_sink_model
  import repair_hdr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Header stream
  input wire beat_t beat_i,
  input wire logic valid_i,
  output logic ready_o,
  // Collected frame
  output logic [223:0] frame_o,
  output logic [7:0] frames_o,
  output logic [4:0] last_pos_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] stall_r;
  logic [4:0] pos_r;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stall_r <= 2'h0;
      pos_r <= 5'h00;
      ready_o <= 1'b0;
      frame_o <= '0;
      frames_o <= 8'h00;
      last_pos_o <= 5'h00;
    end else begin
      stall_r <= stall_r + 2'h1;
      // Periodic stall so every beat must stand until taken
      ready_o <= stall_r != 2'h3;
      if (valid_i && ready_o) begin
        frame_o <= {frame_o[215:0], beat_i.data};
        pos_r <= beat_i.last ? 5'h00 : pos_r + 5'h01;
        if (beat_i.last) begin
          frames_o <= frames_o + 8'h01;
          last_pos_o <= pos_r;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_parity_fec_repair_header.sv
/*
  Self-checking bench of the repair header builder.
  Assumes the sink model and the checker are compiled alongside.
*/
`default_nettype none
`include "repair_hdr_defines.svh"
module tb_parity_fec_repair_header
  import repair_hdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] n;
    logic [7:0] c;
    logic [15:0] fs;
  } row_t;
  // Rows per column, columns, first source sequence number
  row_t rows [3] = '{'{8'h01, 8'h01, 16'h0005}, '{8'h03, 8'hff, 16'hfffe},
    '{8'h04, 8'h0a, 16'h8000}};
  logic core_clk, rst, awv, wv, brdy, arv, rrdy, sv;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, sq, ss, pst;
  logic [1:0] rsp, br, rr;
  logic awr, s_wr, bv, arr, rv, srdy, hv, hrdy;
  logic [31:0] rdo;
  src_fields_t src_f, x;
  beat_t bt;
  logic [223:0] fr, ex;
  logic [7:0] nfr;
  logic [4:0] lpos;
  int n_fail, checked, t;

  repair_hdr_builder u_repair_hdr_builder (.core_clk_i(core_clk), .rst_i(rst),
    .s_awaddr_i(awa), .s_awvalid_i(awv), .s_awready_o(awr), .s_wdata_i(wd),
    .s_wstrb_i(4'hf), .s_wvalid_i(wv), .s_wready_o(s_wr), .s_bresp_o(br),
    .s_bvalid_o(bv), .s_bready_i(brdy), .s_araddr_i(ara), .s_arvalid_i(arv),
    .s_arready_o(arr), .s_rdata_o(rdo), .s_rresp_o(rr), .s_rvalid_o(rv),
    .s_rready_i(rrdy), .src_fields_i(src_f), .src_valid_i(sv), .src_ready_o(srdy),
    .hdr_beat_o(bt), .hdr_valid_o(hv), .hdr_ready_i(hrdy));
  hdr_sink_model u_hdr_sink_model (.core_clk_i(core_clk), .rst_i(rst), .beat_i(bt),
    .valid_i(hv), .ready_o(hrdy), .frame_o(fr), .frames_o(nfr), .last_pos_o(lpos));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [223:0] e, input logic [223:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic ah, wh;
    ah = 1'b1;
    wh = 1'b1;
    @(posedge core_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    while (ah || wh) begin
      @(posedge core_clk);
      if (ah && awr) awv <= 1'b0;
      if (ah && awr) ah = 1'b0;
      if (wh && s_wr) wv <= 1'b0;
      if (wh && s_wr) wh = 1'b0;
    end
    do @(posedge core_clk); while (!bv);
    rsp = br;
    brdy <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    @(posedge core_clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do @(posedge core_clk); while (!arr);
    arv <= 1'b0;
    do @(posedge core_clk); while (!rv);
    rd = rdo;
    rsp = rr;
    rrdy <= 1'b0;
  endtask

  // Hands one column of sources over back to back and folds them for reference
  task automatic feed(input row_t r);
    src_fields_t f;
    x = '0;
    @(posedge core_clk);
    for (int k = 0; k < int'(r.n); k++) begin
      f.padding = k[0];
      f.extension = k[1];
      f.csrc_count = 4'(k) + 4'h3;
      f.marker = ~k[0];
      f.ptype = 7'h21 + 7'(k);
      // Descending order makes the lowest number arrive last, across the wrap
      f.seq = r.fs + 16'(int'(r.n) - 1 - k);
      f.stamp = 32'h01020304 * 32'(k + 1);
      f.length = 16'h0040 + 16'(k * 3);
      x = x ^ f;
      src_f <= f;
      sv <= 1'b1;
      do @(posedge core_clk); while (!srdy);
    end
    sv <= 1'b0;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, awv, wv, brdy, arv, rrdy, sv} = 7'h40;
    {awa, ara, wd, src_f} = '0;
    pst = 32'h00000000;
    repeat (6) @(posedge core_clk);
    chk("reset stream", 224'(0), 224'({hv, srdy}));
    rst <= 1'b0;
    axi_wr(`REG_SEED, 32'h5a5a1234);
    axi_wr(`REG_PTYPE, 32'h00000060);
    axi_wr(`REG_CTRL, 32'h00000002);
    axi_wr(`REG_CTRL, 32'h00000001);
    axi_rd(`REG_SEQ);
    sq = rd;
    axi_rd(`REG_SSRC);
    ss = rd;
    for (int i = 0; i < 3; i++) begin
      axi_wr(`REG_BLOCK, {16'h0000, rows[i].n, rows[i].c});
      feed(rows[i]);
      t = 0;
      while (nfr != 8'(i + 1) && t < 500) begin
        @(posedge core_clk);
        t++;
      end
      ex = {2'h2, x.padding, x.extension, x.csrc_count, x.marker, 7'h60, sq[15:0],
        fr[191:160], ss, rows[i].fs, x.length, 1'b1, x.ptype, 24'h0, x.stamp,
        8'h00, rows[i].c, rows[i].n, 8'h00};
      chk("repair frame", ex, fr);
      chk("last position", 224'(5'h1b), 224'(lpos));
      axi_rd(`REG_TIME);
      chk("stamp order", 224'(1), 224'(fr[191:160] > pst && fr[191:160] < rd));
      pst = fr[191:160];
      sq = {16'h0000, sq[15:0] + 16'h0001};
      $display("test row %0d done", i);
    end
    axi_wr(`REG_SEQ, 32'h00000000);
    chk("read-only write", 224'(`RESP_OKAY), 224'(rsp));
    axi_rd(`REG_SEQ);
    chk("next sequence", 224'(sq), 224'(rd));
    axi_wr(`REG_CTRL, 32'h00000005);
    axi_rd(`REG_SSRC);
    chk("ssrc redrawn", 224'(1), 224'(rd !== ss));
    axi_rd(12'h020);
    chk("unmapped read", 224'({`RESP_SLVERR, 32'h0}), 224'({rsp, rd}));
    axi_wr(12'h024, 32'h00000001);
    chk("unmapped write", 224'(`RESP_SLVERR), 224'(rsp));
    $display("test registers done");
    for (int j = 0; j < 2; j++) begin
      axi_wr(`REG_BLOCK, j == 0 ? 32'h0000000a : 32'h00000300);
      axi_rd(`REG_STATUS);
      chk("zero count status", 224'({16'h0003, 16'h0001}), 224'(rd));
      sv <= 1'b1;
      repeat (8) @(posedge core_clk);
      chk("zero count refusal", 224'(0), 224'({hv, srdy}));
      sv <= 1'b0;
    end
    $display("test zero count done");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
